// >>> hw/iofa_core.sv
// The placing of the registers and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/100ps
// Notes on behaviour
// - Self-check always; failure halts the program
// - Errors set summary flags, stop lamp blinks
// - Run/stop commands only in remote position
// - Pause halts scanning, outputs hold level
// - Debug runs only the requested scan count
// - Remote reset clears error state
// - Per-point force values, gated by global enable
// - Forced inputs substituted into input image
// - Forced outputs driven, output image untouched
// - Force table covers remote I/O range
// - Force settings survive reset and mode changes
// - Load, backup loss, flash restart clear forcing
// - Direct input refreshes input image immediately
// - Direct output sends image to outputs immediately
// - Forcing also applies to direct transfers
// - Fatal faults stop, warnings let run
// - Nonzero fault word at scan end trips
// - Eight sixteen-bit fault code words
// - Remote only after stop-to-remote selector move
// - Reject forbidden remote mode transitions
// - Link commands ignored when communication disabled, except the force-clear, load and flash bits
module iofa_core
	import iofa_pkg::*;
#(
	parameter int EXEC_CYC = iofa_pkg::EXEC_CYC_DEF,
	parameter int BLINK_CYC = iofa_pkg::BLINK_CYC_DEF
) (
	input wire logic i_core_clk,
	input wire logic i_reset_n,
	input wire logic i_axi_awvalid,
	output logic o_axi_awready,
	input wire logic [iofa_pkg::AXI_AW-1:0] i_axi_awaddr,
	input wire logic i_axi_wvalid,
	output logic o_axi_wready,
	input wire logic [iofa_pkg::AXI_DW-1:0] i_axi_wdata,
	input wire logic [iofa_pkg::AXI_SW-1:0] i_axi_wstrb,
	output logic o_axi_bvalid,
	input wire logic i_axi_bready,
	output logic [1:0] o_axi_bresp,
	input wire logic i_axi_arvalid,
	output logic o_axi_arready,
	input wire logic [iofa_pkg::AXI_AW-1:0] i_axi_araddr,
	output logic o_axi_rvalid,
	input wire logic i_axi_rready,
	output logic [iofa_pkg::AXI_DW-1:0] o_axi_rdata,
	output logic [1:0] o_axi_rresp,
	input wire logic [1:0] i_sel_pos,
	input wire logic i_selftest_fail,
	input wire logic i_backup_fail,
	input wire logic [iofa_pkg::PHYS_W-1:0] i_in_pins,
	input wire logic [iofa_pkg::IMG_W-iofa_pkg::PHYS_W-1:0] i_remote_in,
	output logic [iofa_pkg::PHYS_W-1:0] o_out_pins,
	output logic [iofa_pkg::IMG_W-iofa_pkg::PHYS_W-1:0] o_remote_out,
	output logic o_stop_led
);
	import iofa_pkg::*;

	localparam int CW = $clog2(EXEC_CYC + 1);
	localparam logic [CW-1:0] EXEC_LAST = CW'(EXEC_CYC - 1);
	localparam logic [31:0] BLINK_LAST = 32'(BLINK_CYC - 1);
	localparam int SYNC_W = 2 + 2 + IMG_W;

	logic aw_have_r, w_have_r, awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
	logic [AXI_AW-1:0] aw_addr_r;
	logic [AXI_DW-1:0] w_data_r, rdata_r, rd_data, wd_raw;
	logic [AXI_SW-1:0] w_strb_r;
	logic [1:0] bresp_r, rresp_r;
	logic wr_fire, wr_hit, rd_hit;
	logic [AXI_AW-1:0] wa, ra;
	logic [SYNC_W-1:0] sync_out;
	logic [1:0] sel_f, sel_prev_r;
	logic fail_f, bkfail_f;
	logic [IMG_W-1:0] pins_f;
	iofa_mode_type mode_r;
	iofa_scan_type scan_r;
	logic [CW-1:0] exec_cnt_r;
	logic [DBG_W-1:0] dbg_scans_r, dbg_left_r;
	logic rem_ok_r, comm_en_r, warn_r;
	logic [SYS_W-1:0] sys_err_r;
	logic [IMG_W-1:0] fin_en_r, fin_val_r, fout_en_r, fout_val_r;
	logic force_on_r;
	logic [IMG_W-1:0] in_img_r, out_img_r, out_r, warn_bits_r;
	logic [FAULT_W-1:0] fault_r [FAULT_N];
	logic [31:0] blink_cnt_r;
	logic blink_r, led_r;
	logic cmd_wr, dir_wr, fault_wr, src_ok, rem_acc, rst_cmd, clr_any;
	logic dbg_go, scanning, fault_any, ext_hit, din_go, dout_go;
	logic [2:0] wa_idx, ra_idx;

	function automatic logic [AXI_DW-1:0] wmerge(input logic [AXI_DW-1:0] old,
			input logic [AXI_DW-1:0] dat, input logic [AXI_SW-1:0] strb);
		logic [AXI_DW-1:0] res;
		res = old;
		for (int b = 0; b < AXI_SW; b++) begin
			if (strb[b]) begin
				res[8*b +: 8] = dat[8*b +: 8];
			end
		end
		return res;
	endfunction

	// One overlay serves refresh and direct transfers alike
	function automatic logic [IMG_W-1:0] frc(input logic [IMG_W-1:0] v,
			input logic [IMG_W-1:0] en, input logic [IMG_W-1:0] val, input logic on);
		return on ? ((v & ~en) | (val & en)) : v;
	endfunction

	iofa_sync3 #(.W(SYNC_W)) u_sync (
		.i_core_clk(i_core_clk),
		.i_reset_n(i_reset_n),
		.i_async({i_sel_pos, i_selftest_fail, i_backup_fail, i_remote_in, i_in_pins}),
		.o_sync(sync_out)
	);
	assign sel_f = sync_out[SYNC_W-1 -: 2];
	assign fail_f = sync_out[IMG_W+1];
	assign bkfail_f = sync_out[IMG_W];
	assign pins_f = sync_out[IMG_W-1:0];

	// Bus slave, write side: address and data taken in either order
	assign wa = {aw_addr_r[AXI_AW-1:2], 2'h0};
	assign wa_idx = 3'((wa - OFF_FAULT0) >> 2);
	assign fault_wr = (wa >= OFF_FAULT0) && (wa <= OFF_FAULT7);
	assign wr_fire = aw_have_r & w_have_r & ~bvalid_r;
	assign wr_hit = fault_wr || (wa <= OFF_DIRECT && wa != OFF_STAT && wa != OFF_IN_IMG);
	assign wd_raw = wmerge('0, w_data_r, w_strb_r);

	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			aw_have_r <= 1'b0;
			w_have_r <= 1'b0;
			awready_r <= 1'b1;
			wready_r <= 1'b1;
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
			aw_addr_r <= '0;
			w_data_r <= '0;
			w_strb_r <= '0;
		end else begin
			if (i_axi_awvalid && awready_r) begin
				aw_have_r <= 1'b1;
				awready_r <= 1'b0;
				aw_addr_r <= i_axi_awaddr;
			end
			if (i_axi_wvalid && wready_r) begin
				w_have_r <= 1'b1;
				wready_r <= 1'b0;
				w_data_r <= i_axi_wdata;
				w_strb_r <= i_axi_wstrb;
			end
			if (wr_fire) begin
				aw_have_r <= 1'b0;
				w_have_r <= 1'b0;
				bvalid_r <= 1'b1;
				bresp_r <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end
			if (bvalid_r && i_axi_bready) begin
				bvalid_r <= 1'b0;
				awready_r <= 1'b1;
				wready_r <= 1'b1;
			end
		end
	end

	// Read side
	assign ra = {i_axi_araddr[AXI_AW-1:2], 2'h0};
	assign ra_idx = 3'((ra - OFF_FAULT0) >> 2);
	always_comb begin
		rd_data = '0;
		rd_hit = 1'b1;
		if (ra >= OFF_FAULT0 && ra <= OFF_FAULT7) begin
			rd_data[FAULT_W-1:0] = fault_r[ra_idx];
		end else begin
			unique case (ra)
				OFF_CMD, OFF_DIRECT: rd_data = '0;
				OFF_CFG: begin
					rd_data[CF_COMM] = comm_en_r;
					rd_data[CF_FORCE] = force_on_r;
				end
				OFF_STAT: begin
					rd_data[ST_MODE_LSB +: 3] = mode_r;
					rd_data[ST_ERR] = |sys_err_r;
					rd_data[ST_WARN] = warn_r;
					rd_data[ST_REM] = rem_ok_r;
					rd_data[ST_SYS_LSB +: SYS_W] = sys_err_r;
				end
				OFF_DBG: rd_data[DBG_W-1:0] = dbg_scans_r;
				OFF_FIN_EN: rd_data = fin_en_r;
				OFF_FIN_VAL: rd_data = fin_val_r;
				OFF_FOUT_EN: rd_data = fout_en_r;
				OFF_FOUT_VAL: rd_data = fout_val_r;
				OFF_IN_IMG: rd_data = in_img_r;
				OFF_OUT_IMG: rd_data = out_img_r;
				OFF_WARN: rd_data = warn_bits_r;
				default: rd_hit = 1'b0;
			endcase
		end
	end

	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			arready_r <= 1'b1;
			rvalid_r <= 1'b0;
			rdata_r <= '0;
			rresp_r <= RESP_OKAY;
		end else if (i_axi_arvalid && arready_r) begin
			arready_r <= 1'b0;
			rvalid_r <= 1'b1;
			rdata_r <= rd_data;
			rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid_r && i_axi_rready) begin
			rvalid_r <= 1'b0;
			arready_r <= 1'b1;
		end
	end

	// Command decode
	assign cmd_wr = wr_fire && wa == OFF_CMD;
	assign dir_wr = wr_fire && wa == OFF_DIRECT;
	assign src_ok = !wd_raw[CB_LINK] || comm_en_r;
	assign rem_acc = cmd_wr && src_ok && rem_ok_r && sel_f == SEL_REM;
	assign rst_cmd = cmd_wr && src_ok && wd_raw[CB_RESET];
	assign dbg_go = rem_acc && mode_r == MD_STOP && wd_raw[CB_DEBUG] &&
		!wd_raw[CB_STOP] && !wd_raw[CB_RUN];
	assign clr_any = bkfail_f || (cmd_wr && (wd_raw[CB_FCLR] || wd_raw[CB_LOAD] ||
		wd_raw[CB_FLASH]));
	assign scanning = mode_r == MD_RUN || (mode_r == MD_DEBUG && dbg_left_r != '0);
	assign din_go = dir_wr && wd_raw[DB_IN] && scanning && scan_r == SC_EXEC;
	assign dout_go = dir_wr && wd_raw[DB_OUT] && scanning && scan_r == SC_EXEC;
	always_comb begin
		fault_any = 1'b0;
		for (int n = 0; n < FAULT_N; n++) begin
			fault_any = fault_any | (fault_r[n] != '0);
		end
	end
	assign ext_hit = scanning && scan_r == SC_CHK && fault_any;

	// Software-written state
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			comm_en_r <= 1'b0;
			dbg_scans_r <= '0;
			out_img_r <= '0;
			warn_bits_r <= '0;
			for (int n = 0; n < FAULT_N; n++) begin
				fault_r[n] <= '0;
			end
		end else if (wr_fire) begin
			if (wa == OFF_CFG && w_strb_r[0]) begin
				comm_en_r <= w_data_r[CF_COMM];
			end
			if (wa == OFF_DBG) begin
				dbg_scans_r <= DBG_W'(wmerge(AXI_DW'(dbg_scans_r), w_data_r, w_strb_r));
			end
			if (wa == OFF_OUT_IMG) begin
				out_img_r <= wmerge(out_img_r, w_data_r, w_strb_r);
			end
			if (wa == OFF_WARN) begin
				warn_bits_r <= wmerge(warn_bits_r, w_data_r, w_strb_r);
			end
			if (fault_wr) begin
				fault_r[wa_idx] <= FAULT_W'(wmerge(AXI_DW'(fault_r[wa_idx]), w_data_r, w_strb_r));
			end
		end
	end

	// Force table has no reset so it outlives reset and mode changes
	always_ff @(posedge i_core_clk) begin
		if (clr_any) begin
			fin_en_r <= '0;
			fout_en_r <= '0;
			fin_val_r <= '0;
			fout_val_r <= '0;
			force_on_r <= 1'b0;
		end else if (wr_fire) begin
			if (wa == OFF_CFG && w_strb_r[0]) begin
				force_on_r <= w_data_r[CF_FORCE];
			end
			if (wa == OFF_FIN_EN) begin
				fin_en_r <= wmerge(fin_en_r, w_data_r, w_strb_r);
			end
			if (wa == OFF_FIN_VAL) begin
				fin_val_r <= wmerge(fin_val_r, w_data_r, w_strb_r);
			end
			if (wa == OFF_FOUT_EN) begin
				fout_en_r <= wmerge(fout_en_r, w_data_r, w_strb_r);
			end
			if (wa == OFF_FOUT_VAL) begin
				fout_val_r <= wmerge(fout_val_r, w_data_r, w_strb_r);
			end
		end
	end

	// Operating mode
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			mode_r <= MD_STOP;
			sel_prev_r <= SEL_STOP;
			rem_ok_r <= 1'b0;
		end else begin
			sel_prev_r <= sel_f;
			if (sel_f != SEL_REM) begin
				rem_ok_r <= 1'b0;
			end else if (sel_prev_r == SEL_STOP) begin
				rem_ok_r <= 1'b1;
			end
			if (fail_f || ext_hit) begin
				mode_r <= MD_ERROR;
			end else if (rst_cmd) begin
				mode_r <= MD_STOP;
			end else if (mode_r != MD_ERROR && sel_f != sel_prev_r) begin
				if (sel_f == SEL_RUN) begin
					mode_r <= MD_RUN;
				end else if (sel_f == SEL_REM && sel_prev_r == SEL_RUN) begin
					mode_r <= MD_PAUSE;
				end else begin
					mode_r <= MD_STOP;
				end
			end else if (rem_acc) begin
				unique case (mode_r)
					MD_STOP: begin
						if (wd_raw[CB_RUN] && !wd_raw[CB_STOP]) begin
							mode_r <= MD_RUN;
						end else if (dbg_go) begin
							mode_r <= MD_DEBUG;
						end
					end
					MD_RUN: begin
						if (wd_raw[CB_STOP]) begin
							mode_r <= MD_STOP;
						end else if (wd_raw[CB_PAUSE]) begin
							mode_r <= MD_PAUSE;
						end
					end
					MD_PAUSE: begin
						if (wd_raw[CB_STOP]) begin
							mode_r <= MD_STOP;
						end else if (wd_raw[CB_RUN]) begin
							mode_r <= MD_RUN;
						end
					end
					MD_DEBUG: begin
						if (wd_raw[CB_STOP]) begin
							mode_r <= MD_STOP;
						end
					end
					MD_ERROR: mode_r <= MD_ERROR;
				endcase
			end
		end
	end

	// Error and warning flags; a new set beats a reset in the same cycle
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			sys_err_r <= '0;
			warn_r <= 1'b0;
		end else begin
			sys_err_r[SE_SELF] <= fail_f | (sys_err_r[SE_SELF] & ~rst_cmd);
			sys_err_r[SE_EXT] <= ext_hit | (sys_err_r[SE_EXT] & ~rst_cmd);
			if (scanning && scan_r == SC_CHK) begin
				warn_r <= |warn_bits_r;
			end else if (rst_cmd) begin
				warn_r <= 1'b0;
			end
		end
	end

	// Scan sequencer
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			scan_r <= SC_IN;
			exec_cnt_r <= '0;
		end else if (!scanning) begin
			scan_r <= SC_IN;
			exec_cnt_r <= '0;
		end else begin
			unique case (scan_r)
				SC_IN: scan_r <= SC_EXEC;
				SC_EXEC: begin
					exec_cnt_r <= exec_cnt_r + 1'b1;
					if (exec_cnt_r == EXEC_LAST) begin
						exec_cnt_r <= '0;
						scan_r <= SC_CHK;
					end
				end
				SC_CHK: scan_r <= SC_OUT;
				SC_OUT: scan_r <= SC_IN;
			endcase
		end
	end

	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			dbg_left_r <= '0;
		end else if (dbg_go) begin
			dbg_left_r <= dbg_scans_r;
		end else if (mode_r == MD_DEBUG && scanning && scan_r == SC_OUT) begin
			dbg_left_r <= dbg_left_r - 1'b1;
		end
	end

	// Images and pins
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			in_img_r <= '0;
		end else if ((scanning && scan_r == SC_IN) || din_go) begin
			in_img_r <= frc(pins_f, fin_en_r, fin_val_r, force_on_r);
		end
	end

	// Overlay lands on the pins only; the output image stays as written
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			out_r <= '0;
		end else if (mode_r == MD_STOP || mode_r == MD_ERROR) begin
			out_r <= '0;
		end else if ((scanning && scan_r == SC_OUT) || dout_go) begin
			out_r <= frc(out_img_r, fout_en_r, fout_val_r, force_on_r);
		end
	end

	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			blink_cnt_r <= '0;
			blink_r <= 1'b0;
			led_r <= 1'b0;
		end else begin
			blink_cnt_r <= (blink_cnt_r >= BLINK_LAST) ? '0 : blink_cnt_r + 1'b1;
			if (blink_cnt_r >= BLINK_LAST) begin
				blink_r <= ~blink_r;
			end
			led_r <= (mode_r == MD_ERROR) ? blink_r : (mode_r == MD_STOP);
		end
	end

	assign o_axi_awready = awready_r;
	assign o_axi_wready = wready_r;
	assign o_axi_bvalid = bvalid_r;
	assign o_axi_bresp = bresp_r;
	assign o_axi_arready = arready_r;
	assign o_axi_rvalid = rvalid_r;
	assign o_axi_rdata = rdata_r;
	assign o_axi_rresp = rresp_r;
	assign o_out_pins = out_r[PHYS_W-1:0];
	assign o_remote_out = out_r[IMG_W-1:PHYS_W];
	assign o_stop_led = led_r;

	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!i_reset_n);

	sequence chk_step;
		scanning && scan_r == SC_CHK;
	endsequence
	sequence out_step;
		scanning && scan_r == SC_OUT;
	endsequence

	selftest_halt_a: assert property (fail_f |=> mode_r == MD_ERROR && sys_err_r[SE_SELF])
		else $error("self-check failure did not halt");
	err_led_a: assert property (mode_r == MD_ERROR && $past(mode_r) == MD_ERROR |=>
		led_r == $past(blink_r))
		else $error("stop lamp not blinking in error");
	remote_gate_a: assert property ($past(mode_r) == MD_STOP && mode_r == MD_RUN |->
		sel_f == SEL_RUN || $past(rem_ok_r))
		else $error("run taken outside remote position");
	pause_hold_a: assert property (mode_r == MD_PAUSE && $past(mode_r) == MD_PAUSE |->
		$stable(out_r))
		else $error("outputs moved during pause");
	no_stop_pause_a: assert property ($past(mode_r) == MD_STOP |-> mode_r != MD_PAUSE)
		else $error("stop to pause transition taken");
	force_clear_a: assert property (clr_any |=> fin_en_r == '0 && fout_en_r == '0 && !force_on_r)
		else $error("force settings not cleared");
	image_kept_a: assert property (dout_go |=> $stable(out_img_r) ##0
		out_r == frc($past(out_img_r), fout_en_r, fout_val_r, force_on_r))
		else $error("direct output wrong or image changed");
	direct_in_a: assert property (din_go |=>
		in_img_r == frc($past(pins_f), $past(fin_en_r), $past(fin_val_r), $past(force_on_r)))
		else $error("direct input did not refresh image");
	ext_trip_a: assert property (chk_step ##0 (fault_any && !fail_f) |=>
		mode_r == MD_ERROR && sys_err_r[SE_EXT] ##1 out_r == '0)
		else $error("external fault did not trip");
	// A stop or trip during the check phase still passes through output
	scan_order_a: assert property (chk_step |=> scan_r == SC_OUT)
		else $error("scan phases out of order");
	scan_wrap_a: assert property (out_step |=> scan_r == SC_IN)
		else $error("scan did not restart at input");
endmodule

// >>> hw/iofa_pkg.sv
package iofa_pkg;
	localparam int AXI_AW = 8;
	localparam int AXI_DW = 32;
	localparam int AXI_SW = AXI_DW / 8;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	localparam logic [AXI_AW-1:0] OFF_CMD = 8'h00;
	localparam logic [AXI_AW-1:0] OFF_CFG = 8'h04;
	localparam logic [AXI_AW-1:0] OFF_STAT = 8'h08;
	localparam logic [AXI_AW-1:0] OFF_DBG = 8'h0c;
	localparam logic [AXI_AW-1:0] OFF_FIN_EN = 8'h10;
	localparam logic [AXI_AW-1:0] OFF_FIN_VAL = 8'h14;
	localparam logic [AXI_AW-1:0] OFF_FOUT_EN = 8'h18;
	localparam logic [AXI_AW-1:0] OFF_FOUT_VAL = 8'h1c;
	localparam logic [AXI_AW-1:0] OFF_IN_IMG = 8'h20;
	localparam logic [AXI_AW-1:0] OFF_OUT_IMG = 8'h24;
	localparam logic [AXI_AW-1:0] OFF_WARN = 8'h28;
	localparam logic [AXI_AW-1:0] OFF_DIRECT = 8'h2c;
	localparam logic [AXI_AW-1:0] OFF_FAULT0 = 8'h40;
	localparam logic [AXI_AW-1:0] OFF_FAULT7 = 8'h5c;

	// Command word bits
	localparam int CB_RUN = 0;
	localparam int CB_STOP = 1;
	localparam int CB_PAUSE = 2;
	localparam int CB_DEBUG = 3;
	localparam int CB_RESET = 4;
	localparam int CB_LINK = 5;
	localparam int CB_FCLR = 6;
	localparam int CB_LOAD = 7;
	localparam int CB_FLASH = 8;
	// Config, direct and status bits
	localparam int CF_COMM = 0;
	localparam int CF_FORCE = 1;
	localparam int DB_IN = 0;
	localparam int DB_OUT = 1;
	localparam int ST_MODE_LSB = 0;
	localparam int ST_ERR = 3;
	localparam int ST_WARN = 4;
	localparam int ST_REM = 5;
	localparam int ST_SYS_LSB = 8;
	localparam int SYS_W = 2;
	localparam int SE_SELF = 0;
	localparam int SE_EXT = 1;

	localparam logic [1:0] SEL_STOP = 2'h0;
	localparam logic [1:0] SEL_REM = 2'h1;
	localparam logic [1:0] SEL_RUN = 2'h2;

	localparam int FAULT_N = 8;
	localparam int FAULT_W = 16;
	localparam int IMG_W = 32;
	localparam int PHYS_W = 16;
	localparam int DBG_W = 16;
	localparam int EXEC_CYC_DEF = 32;
	localparam int CLK_HZ = 25_000_000;
	localparam int BLINK_MS = 250;
	localparam int BLINK_CYC_DEF = BLINK_MS * (CLK_HZ / 1000);

	typedef enum logic [2:0] {MD_STOP, MD_RUN, MD_PAUSE, MD_DEBUG, MD_ERROR} iofa_mode_type;
	typedef enum logic [1:0] {SC_IN, SC_EXEC, SC_CHK, SC_OUT} iofa_scan_type;
endpackage

// >>> hw/iofa_sync3.sv
`timescale 1ns/100ps
module iofa_sync3 #(
	parameter int W = 1
) (
	input wire logic i_core_clk,
	input wire logic i_reset_n,
	input wire logic [W-1:0] i_async,
	output logic [W-1:0] o_sync
);
	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;

	// A bit only moves once stages two and three agree
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
			o_sync <= '0;
		end else begin
			s1_r <= i_async;
			s2_r <= s1_r;
			s3_r <= s2_r;
			for (int b = 0; b < W; b++) begin
				if (s2_r[b] == s3_r[b]) begin
					o_sync[b] <= s3_r[b];
				end
			end
		end
	end
endmodule

// >>> sim/iofa_io_model.sv
`timescale 1ns/100ps
module iofa_io_model
	import iofa_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic [iofa_pkg::IMG_W-1:0] i_field,
	input wire logic [iofa_pkg::PHYS_W-1:0] i_out_pins,
	input wire logic [iofa_pkg::IMG_W-iofa_pkg::PHYS_W-1:0] i_remote_out,
	output logic [iofa_pkg::PHYS_W-1:0] o_in_pins,
	output logic [iofa_pkg::IMG_W-iofa_pkg::PHYS_W-1:0] o_remote_in,
	output logic [iofa_pkg::IMG_W-1:0] o_loads
);
	initial begin
		o_in_pins = '0;
		o_remote_in = '0;
	end
	// Contacts change on an edge, after the core has sampled them
	always @(posedge i_core_clk) begin
		o_in_pins <= i_field[PHYS_W-1:0];
		o_remote_in <= i_field[IMG_W-1:PHYS_W];
	end
	assign o_loads = {i_remote_out, i_out_pins};
endmodule

// >>> sim/test_io_image_force_fault_annunciator.sv
`timescale 1ns/100ps
module test_io_image_force_fault_annunciator;
	import iofa_pkg::*;
	typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] q; logic [1:0] r;} iofa_row_type;
	logic clk = 0;
	logic rst_n = 0;
	logic awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, stf = 0, bkf = 1;
	logic [7:0] awa = 0, ara = 0;
	logic [31:0] wd = 0, rdat, loads;
	logic [31:0] field = 32'h0000_00a4;
	logic [1:0] sel = SEL_STOP;
	logic [1:0] br, rr;
	logic awr, wr_, bv, arr, rv, led;
	logic [15:0] inp, rin, outp, rout;
	int n_errors = 0;
	int n_checks = 0;
	iofa_row_type rows[12] = '{
		'{OFF_CFG, 32'h2, 32'h2, RESP_OKAY},
		'{OFF_FIN_EN, 32'h0010_0003, 32'h0010_0003, RESP_OKAY},
		'{OFF_FIN_VAL, 32'h0010_0001, 32'h0010_0001, RESP_OKAY},
		'{OFF_FOUT_EN, 32'h0001_0011, 32'h0001_0011, RESP_OKAY},
		'{OFF_FOUT_VAL, 32'h0001_0001, 32'h0001_0001, RESP_OKAY},
		'{OFF_OUT_IMG, 32'hf0, 32'hf0, RESP_OKAY},
		'{OFF_DBG, 32'h2, 32'h2, RESP_OKAY},
		'{OFF_FAULT0, 32'hffff_0000, 32'h0, RESP_OKAY},
		'{OFF_FAULT7, 32'h0001_0000, 32'h0, RESP_OKAY},
		'{OFF_CMD, 32'h0, 32'h0, RESP_OKAY},
		'{OFF_STAT, 32'hff, 32'h0, RESP_SLVERR},
		'{8'h30, 32'h5, 32'h0, RESP_SLVERR}};
	always #20 clk = ~clk;
	iofa_core #(.EXEC_CYC(4), .BLINK_CYC(4)) u_dut (.i_core_clk(clk), .i_reset_n(rst_n),
		.i_axi_awvalid(awv), .o_axi_awready(awr), .i_axi_awaddr(awa), .i_axi_wvalid(wv),
		.o_axi_wready(wr_), .i_axi_wdata(wd), .i_axi_wstrb(4'hf), .o_axi_bvalid(bv),
		.i_axi_bready(bry), .o_axi_bresp(br), .i_axi_arvalid(arv), .o_axi_arready(arr),
		.i_axi_araddr(ara), .o_axi_rvalid(rv), .i_axi_rready(rry), .o_axi_rdata(rdat),
		.o_axi_rresp(rr), .i_sel_pos(sel), .i_selftest_fail(stf), .i_backup_fail(bkf),
		.i_in_pins(inp), .i_remote_in(rin), .o_out_pins(outp), .o_remote_out(rout),
		.o_stop_led(led));
	iofa_io_model u_io (.i_core_clk(clk), .i_field(field), .i_out_pins(outp),
		.i_remote_out(rout), .o_in_pins(inp), .o_remote_in(rin), .o_loads(loads));
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic done(input string s);
		$display("test %s finished", s);
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// Address and data offered together, each dropped once taken
	task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		bit ad, dd;
		ad = 0;
		dd = 0;
		@(posedge clk);
		awv <= 1;
		awa <= a;
		wv <= 1;
		wd <= d;
		bry <= 1;
		while (!(ad && dd)) begin
			@(posedge clk);
			if (awr === 1'b1)
				ad = 1;
			if (wr_ === 1'b1)
				dd = 1;
			awv <= !ad;
			wv <= !dd;
		end
		do @(posedge clk); while (bv !== 1'b1);
		r = br;
		bry <= 0;
	endtask
	task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		arv <= 1;
		ara <= a;
		rry <= 1;
		do @(posedge clk); while (arr !== 1'b1);
		arv <= 0;
		do @(posedge clk); while (rv !== 1'b1);
		d = rdat;
		r = rr;
		rry <= 0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] r;
		axw(a, d, r);
	endtask
	task automatic sts(input logic [31:0] m, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		axr(OFF_STAT, d, r);
		chk("status", d & m, e);
	endtask
	// Mode changes have no fixed latency, so poll with a bound
	task automatic mode(input int w, input logic [2:0] m);
		logic [31:0] d;
		logic [1:0] r;
		repeat (w) @(posedge clk);
		for (int i = 0; i < 40; i++) begin
			axr(OFF_STAT, d, r);
			if (d[2:0] === m)
				break;
		end
		chk("mode", d[2:0], m);
	endtask
	initial begin
		#800000;
		n_errors++;
		print_verdict();
	end
	initial begin
		logic [31:0] d;
		logic [1:0] r;
		logic p;
		int k;
		repeat (4) @(posedge clk);
		rst_n <= 1;
		repeat (2) @(posedge clk);
		chk("led", led, 1);
		chk("outs", {rout, outp}, 0);
		chk("ready", {awr, wr_, arr}, 3'h7);
		repeat (10) @(posedge clk);
		bkf <= 0;
		done("reset");
		wr(OFF_CMD, 32'h40);
		foreach (rows[i]) begin
			axw(rows[i].a, rows[i].d, r);
			chk("wresp", r, rows[i].r);
			axr(rows[i].a, d, r);
			chk("rdata", d, rows[i].q);
			chk("rresp", r, (rows[i].a == 8'h30) ? RESP_SLVERR : RESP_OKAY);
		end
		done("registers");
		wr(OFF_CMD, 32'h1);
		mode(12, MD_STOP);
		sel <= SEL_REM;
		repeat (8) @(posedge clk);
		sts(32'h20, 32'h20);
		wr(OFF_CMD, 32'h1);
		mode(0, MD_RUN);
		repeat (20) @(posedge clk);
		axr(OFF_IN_IMG, d, r);
		chk("in_img", d, 32'h0010_00a5);
		chk("outs", {rout, outp}, 32'h0001_00e1);
		axr(OFF_OUT_IMG, d, r);
		chk("out_img", d, 32'hf0);
		wr(OFF_WARN, 32'h1);
		repeat (20) @(posedge clk);
		sts(32'h1f, 32'h11);
		wr(OFF_CMD, 32'h8);
		mode(12, MD_RUN);
		wr(OFF_CMD, 32'h4);
		mode(0, MD_PAUSE);
		wr(OFF_OUT_IMG, 32'h0f);
		repeat (20) @(posedge clk);
		chk("held", {rout, outp}, 32'h0001_00e1);
		wr(OFF_CMD, 32'h8);
		mode(12, MD_PAUSE);
		wr(OFF_CMD, 32'h2);
		mode(0, MD_STOP);
		chk("stop_outs", {rout, outp}, 0);
		wr(OFF_CMD, 32'h4);
		mode(12, MD_STOP);
		done("modes");
		wr(OFF_CMD, 32'h8);
		mode(0, MD_DEBUG);
		repeat (30) @(posedge clk);
		chk("dbg_outs", {rout, outp}, 32'h0001_000f);
		wr(OFF_OUT_IMG, 32'h0);
		repeat (30) @(posedge clk);
		chk("dbg_halt", {rout, outp}, 32'h0001_000f);
		wr(OFF_CMD, 32'h1);
		mode(12, MD_DEBUG);
		wr(OFF_CMD, 32'h2);
		mode(0, MD_STOP);
		wr(OFF_CMD, 32'h21);
		mode(12, MD_STOP);
		wr(OFF_CFG, 32'h3);
		wr(OFF_CMD, 32'h21);
		mode(0, MD_RUN);
		repeat (4) begin
			axw(OFF_DIRECT, 32'h3, r);
			chk("dir_resp", r, RESP_OKAY);
		end
		chk("dir_outs", loads, 32'h0001_0001);
		axr(OFF_IN_IMG, d, r);
		chk("dir_in", d, 32'h0010_00a5);
		done("debug_link");
		wr(OFF_FAULT0 + 8'h0c, 32'h7);
		mode(0, MD_ERROR);
		sts(32'h30f, 32'h20c);
		chk("err_outs", {rout, outp}, 0);
		k = 0;
		p = led;
		repeat (20) begin
			@(posedge clk);
			k += (led !== p);
			p = led;
		end
		chk("blink", (k > 3 && k < 6), 1);
		wr(OFF_FAULT0 + 8'h0c, 32'h0);
		wr(OFF_CMD, 32'h10);
		mode(0, MD_STOP);
		sts(32'h308, 32'h0);
		stf <= 1;
		mode(0, MD_ERROR);
		sts(32'h108, 32'h108);
		stf <= 0;
		repeat (8) @(posedge clk);
		wr(OFF_CMD, 32'h10);
		mode(0, MD_STOP);
		done("faults");
		rst_n <= 0;
		repeat (4) @(posedge clk);
		rst_n <= 1;
		axr(OFF_FIN_EN, d, r);
		chk("fin_en", d, 32'h0010_0003);
		axr(OFF_CFG, d, r);
		chk("force_on", d[1], 1);
		wr(OFF_CMD, 32'h80);
		axr(OFF_FIN_EN, d, r);
		chk("load_clr", d, 0);
		wr(OFF_FOUT_EN, 32'h1);
		wr(OFF_CMD, 32'h100);
		axr(OFF_FOUT_EN, d, r);
		chk("flash_clr", d, 0);
		done("retention");
		print_verdict();
	end
endmodule
